// ===== dv/host_model.sv
module host_model
  import dimm_pkg::*;
(
  input wire logic aclk,
  output logic ck_t,
  output logic ck_c,
  output logic [1:0] rank_clk_gate,
  output logic [1:0] rank_select_n,
  output logic [2:0] cmd,
  output logic [BANK_W-1:0] bank_sel,
  output logic [ADDR_W-1:0] addr,
  output logic [BYTES-1:0] write_byte_mask,
  output logic [DQ_W-1:0] dq_i,
  output logic [BYTES-1:0] byte_data_strobe_i,
  output logic scl,
  output logic sda,
  input wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Controller side: link clock stands still between commands
  initial begin
    ck_t = 1'b0;
    ck_c = 1'b1;
    rank_clk_gate = 2'h3;
    rank_select_n = 2'h3;
    cmd = 3'h7;
    bank_sel = '0;
    addr = '0;
    write_byte_mask = '0;
    dq_i = '0;
    byte_data_strobe_i = '0;
    scl = 1'b1;
    sda = 1'b1;
  end

  // Two-wire master: line levels change only while the clock is low, except start and stop
  task automatic sedge(input logic c, input logic d);
    scl <= c;
    sda <= d;
    repeat (4) @(posedge aclk);
  endtask

  task automatic sbit(input logic b, output logic seen);
    sda <= b;
    repeat (4) @(posedge aclk);
    scl <= 1'b1;
    repeat (4) @(posedge aclk);
    seen = sda_line;
    scl <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  task automatic sbyte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) sbit(tx[i], rx[i]);
    sbit(ack_in, ack);
  endtask

  task automatic cyc(input logic [2:0] c, input logic [2:0] b, input logic [15:0] a, input logic [1:0] s);
    cmd <= c;
    bank_sel <= b;
    addr <= a;
    rank_select_n <= s;
    repeat (4) @(posedge aclk);
    ck_t <= 1'b1;
    ck_c <= 1'b0;
    repeat (4) @(posedge aclk);
    ck_t <= 1'b0;
    ck_c <= 1'b1;
    cmd <= 3'h7;
    rank_select_n <= 2'h3;
    bank_sel <= ~b;
    addr <= ~a;
    @(posedge aclk);
  endtask

  // Strobe rises two cycles into the eight-cycle data window
  task automatic beat(input logic [63:0] d, input logic [7:0] m);
    dq_i <= d;
    write_byte_mask <= m;
    repeat (2) @(posedge aclk);
    byte_data_strobe_i <= 8'hff;
    repeat (4) @(posedge aclk);
    byte_data_strobe_i <= 8'h00;
    repeat (2) @(posedge aclk);
    dq_i <= ~d;
    write_byte_mask <= ~m;
    @(posedge aclk);
  endtask
endmodule

// ===== dv/testbench.sv
module testbench
  import dimm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ck_t, ck_c, sda_o, sda_oe, temp_alert_n;
  logic [7:0] awaddr, araddr, write_byte_mask, byte_data_strobe_i, byte_data_strobe_o;
  logic [7:0] byte_data_strobe_c_o, byte_data_strobe_oe;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rank_clk_gate, rank_select_n, term_ctrl, term_active;
  logic [2:0] cmd, bank_sel;
  logic [15:0] addr;
  logic [63:0] dq_i, dq_o, dq_oe;
  logic scl, sda_m, sda_line, dram_reset_n, spd_ack;
  logic [7:0] spd_rx;
  int bad_count, n_checks;

  // Pulled-up two-wire data line
  assign sda_line = sda_m & ~sda_oe;

  dimm_pin_if dut_u (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .ck_t, .ck_c, .rank_clk_gate, .rank_select_n, .term_ctrl, .row_strobe_n(cmd[2]),
    .col_strobe_n(cmd[1]), .write_en_n(cmd[0]), .bank_sel, .addr, .write_byte_mask, .dq_i, .dq_o,
    .dq_oe, .byte_data_strobe_i, .byte_data_strobe_o, .byte_data_strobe_c_o, .byte_data_strobe_oe,
    .term_active, .dram_reset_n, .scl, .sda_i(sda_line), .sda_o, .sda_oe,
    .serial_addr_strap(3'h0), .temp_alert_n);

  host_model host_u (.aclk, .ck_t, .ck_c, .rank_clk_gate, .rank_select_n, .cmd, .bank_sel, .addr,
    .write_byte_mask, .dq_i, .byte_data_strobe_i, .scl, .sda(sda_m), .sda_line);

  // ==========================================================
  // Bus tasks and comparison
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic check(input string nm, input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Ready and answer are sampled mid-cycle, where they are settled before the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t;
    logic [1:0] r;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    aw_t = 1'b0;
    w_t = 1'b0;
    while (!(aw_t && w_t)) begin
      @(negedge aclk);
      aw_t = aw_t || awready === 1'b1;
      w_t = w_t || wready === 1'b1;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    do begin
      @(negedge aclk);
      r = bresp;
    end while (bvalid !== 1'b1);
    @(posedge aclk);
    bready <= 1'b0;
    check("bresp", r, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      d = rdata;
      r = rresp;
    end while (rvalid !== 1'b1);
    @(posedge aclk);
    rready <= 1'b0;
    check("rdata", d, e);
    check("rresp", r, er);
  endtask

  task automatic wr_mem(input logic [63:0] d, input logic [7:0] m, input logic [1:0] s);
    host_u.cyc(CMD_WR, 3'h2, 16'h0001, s);
    host_u.beat(d, m);
    repeat (6) host_u.cyc(3'h7, 3'h0, 16'h0, 2'h3);
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100us;
    bad_count++;
    print_verdict();
  end

  // ==========================================================
  // Tests
  initial begin
    aresetn = 1'b0;
    dram_reset_n = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb, term_ctrl} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(REG_ID, ID_DEF, RESP_OKAY);
    rd(REG_CRIT, 32'h50, RESP_OKAY);
    rd(8'h3c, 32'h0, RESP_SLVERR);
    wr(8'h3c, 32'h1, RESP_SLVERR);
    check("alert", temp_alert_n, 1'b1);
    wr(REG_TEMP, 32'h50, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("alert", temp_alert_n, 1'b0);
    wr(REG_TEMP, 32'h4f, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("alert", temp_alert_n, 1'b1);
    term_ctrl <= 2'h1;
    repeat (6) @(posedge aclk);
    check("term", term_active, 2'h0);
    host_u.cyc(CMD_MRS, MR1_BANK, 16'h0004, 2'h2);
    repeat (2) @(posedge aclk);
    check("term", term_active, 2'h1);
    rd(REG_MODE, 32'h4, RESP_OKAY);
    term_ctrl <= 2'h0;
    host_u.cyc(CMD_ACT, 3'h2, 16'h0001, 2'h2);
    rd(REG_STATUS, 32'h4, RESP_OKAY);
    wr_mem(64'h0123456789abcdef, 8'h00, 2'h2);
    wr_mem(64'hfedcba9876543210, 8'h0f, 2'h2);
    wr_mem(64'h5555aaaa5555aaaa, 8'h00, 2'h3);
    host_u.write_byte_mask <= 8'hff;
    fork
      begin
        host_u.cyc(CMD_RD, 3'h2, 16'h0401, 2'h2);
        repeat (6) host_u.cyc(3'h7, 3'h0, 16'h0, 2'h3);
      end
      begin
        repeat (100) if (dq_oe[0] !== 1'b1) @(negedge aclk);
        check("dq", dq_o, 64'hfedcba9889abcdef);
        check("dqs", byte_data_strobe_o, 8'hff);
        check("dqs_c", byte_data_strobe_c_o, 8'h00);
        check("dqs_oe", byte_data_strobe_oe, 8'hff);
      end
    join
    rd(REG_STATUS, 32'h0, RESP_OKAY);
    host_u.cyc(CMD_ACT, 3'h1, 16'h0, 2'h2);
    host_u.cyc(CMD_ACT, 3'h3, 16'h0, 2'h2);
    host_u.cyc(CMD_PRE, 3'h1, 16'h0, 2'h2);
    rd(REG_STATUS, 32'h8, RESP_OKAY);
    host_u.cyc(CMD_PRE, 3'h0, 16'h0400, 2'h2);
    rd(REG_STATUS, 32'h0, RESP_OKAY);
    host_u.rank_clk_gate <= 2'h2;
    host_u.cyc(3'h7, 3'h0, 16'h0, 2'h3);
    rd(REG_STATUS, 32'h0001_0000, RESP_OKAY);
    dram_reset_n <= 1'b0;
    repeat (4) @(posedge aclk);
    dram_reset_n <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(REG_MODE, 32'h0, RESP_OKAY);
    wr(REG_SPD, 32'ha5, RESP_OKAY);
    host_u.sedge(1'b1, 1'b0);
    host_u.sedge(1'b0, 1'b0);
    host_u.sbyte(8'ha1, 1'b1, spd_rx, spd_ack);
    check("spd_ack", spd_ack, 1'b0);
    host_u.sbyte(8'hff, 1'b1, spd_rx, spd_ack);
    check("spd_byte", spd_rx, 8'ha5);
    host_u.sedge(1'b0, 1'b0);
    host_u.sedge(1'b1, 1'b0);
    host_u.sedge(1'b1, 1'b1);
    print_verdict();
  end
endmodule

// ===== hdl/dimm_pin_if.sv
module dimm_pin_if
  import dimm_pkg::*;
#(
  parameter int RANKS = 2,
  parameter int CL = CL_DEF,
  parameter int WL = WL_DEF,
  parameter logic [31:0] ID_VALUE = ID_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic ck_t,
  input wire logic ck_c,
  input wire logic [1:0] rank_clk_gate,
  input wire logic [1:0] rank_select_n,
  input wire logic [1:0] term_ctrl,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_en_n,
  input wire logic [BANK_W-1:0] bank_sel,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [BYTES-1:0] write_byte_mask,
  input wire logic [DQ_W-1:0] dq_i,
  output logic [DQ_W-1:0] dq_o,
  output logic [DQ_W-1:0] dq_oe,
  input wire logic [BYTES-1:0] byte_data_strobe_i,
  output logic [BYTES-1:0] byte_data_strobe_o,
  output logic [BYTES-1:0] byte_data_strobe_c_o,
  output logic [BYTES-1:0] byte_data_strobe_oe,
  output logic [1:0] term_active,
  input wire logic dram_reset_n,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [2:0] serial_addr_strap,
  output logic temp_alert_n
);

  localparam logic [1:0] RANK_EN = (RANKS > 1) ? 2'b11 : 2'b01;

  // ==========================================================
  // Pin synchronisers and edge detection
  pin_in_t pin_in, s1_r, s2_r;
  logic ck_prev_r, scl_prev_r, sda_prev_r;
  logic [BYTES-1:0] strobe_prev_r;

  assign pin_in = {ck_t, ck_c, rank_clk_gate, rank_select_n, term_ctrl, row_strobe_n, col_strobe_n, write_en_n,
                   bank_sel, addr, write_byte_mask, dq_i, byte_data_strobe_i, dram_reset_n, scl, sda_i,
                   serial_addr_strap};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= '0;
      s2_r <= '0;
      ck_prev_r <= 1'b0;
      scl_prev_r <= 1'b0;
      sda_prev_r <= 1'b0;
      strobe_prev_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      ck_prev_r <= s2_r.ck_t;
      scl_prev_r <= s2_r.scl;
      sda_prev_r <= s2_r.sda;
      strobe_prev_r <= s2_r.strobe;
    end
  end

  logic ck_rise, ck_fall, mem_rst, rank_of;
  logic [1:0] take;
  logic [2:0] cmd;
  logic [MEM_AW-1:0] cur_idx;
  logic [NBANK-1:0] open_r [2];
  logic [ADDR_W-1:0] row_r [2][NBANK];

  assign ck_rise = s2_r.ck_t & ~ck_prev_r & ~s2_r.ck_c;
  assign ck_fall = ~s2_r.ck_t & ck_prev_r;
  assign mem_rst = ~s2_r.reset_n;
  assign take = {2{ck_rise}} & s2_r.gate & ~s2_r.sel_n & RANK_EN;
  assign cmd = s2_r.cmd;
  assign rank_of = ~take[0] & take[1];
  assign cur_idx = {rank_of, s2_r.bank[1:0], row_r[rank_of][s2_r.bank][0], s2_r.addr[0]};

  // ==========================================================
  // Write path: lanes captured on their own strobe rise
  logic [3:0] wr_cnt_r;
  logic [MEM_AW-1:0] wr_idx_r;
  logic wr_ap_r, wr_rank_r, wr_commit;
  logic [BANK_W-1:0] wr_bank_r;
  logic [DQ_W-1:0] wr_data_r;
  logic [BYTES-1:0] wr_mask_r;
  logic [DQ_W-1:0] mem_r [1 << MEM_AW];

  assign wr_commit = ck_rise && wr_cnt_r == CNT_ONE;

  always_ff @(posedge aclk) begin
    if (!aresetn || mem_rst) begin
      wr_cnt_r <= '0;
      wr_idx_r <= '0;
      wr_ap_r <= 1'b0;
      wr_rank_r <= 1'b0;
      wr_bank_r <= '0;
      wr_data_r <= '0;
      wr_mask_r <= '0;
    end else begin
      if (|take && cmd == CMD_WR) begin
        wr_cnt_r <= 4'(WL + 1);
        wr_idx_r <= cur_idx;
        wr_ap_r <= s2_r.addr[AP_BIT];
        wr_rank_r <= rank_of;
        wr_bank_r <= s2_r.bank;
      end else if (ck_rise && wr_cnt_r != '0) begin
        wr_cnt_r <= wr_cnt_r - CNT_ONE;
      end
      for (int b = 0; b < BYTES; b++) begin
        if (wr_cnt_r != '0 && s2_r.strobe[b] && !strobe_prev_r[b]) begin
          wr_data_r[8*b +: 8] <= s2_r.dq[8*b +: 8];
          wr_mask_r[b] <= s2_r.mask[b];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (wr_commit) begin
      for (int b = 0; b < BYTES; b++) begin
        if (!wr_mask_r[b]) begin
          mem_r[wr_idx_r][8*b +: 8] <= wr_data_r[8*b +: 8];
        end
      end
    end
  end

  // ==========================================================
  // Read path, launched on incoming clock edges
  logic [3:0] rd_cnt_r;
  logic [MEM_AW-1:0] rd_idx_r;
  logic rd_ap_r, rd_rank_r, rd_launch, rd_drive_r, dqs_r;
  logic [BANK_W-1:0] rd_bank_r;
  logic [DQ_W-1:0] dq_o_r, rd_word;

  assign rd_launch = ck_rise && rd_cnt_r == CNT_ONE;
  assign rd_word = mem_r[rd_idx_r];

  always_ff @(posedge aclk) begin
    if (!aresetn || mem_rst) begin
      rd_cnt_r <= '0;
      rd_idx_r <= '0;
      rd_ap_r <= 1'b0;
      rd_rank_r <= 1'b0;
      rd_bank_r <= '0;
      rd_drive_r <= 1'b0;
      dqs_r <= 1'b0;
      dq_o_r <= '0;
    end else begin
      if (|take && cmd == CMD_RD) begin
        rd_cnt_r <= 4'(CL);
        rd_idx_r <= cur_idx;
        rd_ap_r <= s2_r.addr[AP_BIT];
        rd_rank_r <= rank_of;
        rd_bank_r <= s2_r.bank;
      end else if (ck_rise && rd_cnt_r != '0) begin
        rd_cnt_r <= rd_cnt_r - CNT_ONE;
      end
      if (rd_launch) begin
        dq_o_r <= rd_word;
        rd_drive_r <= 1'b1;
        dqs_r <= 1'b1;
      end else if (ck_rise) begin
        rd_drive_r <= 1'b0;
        dqs_r <= 1'b0;
      end else if (ck_fall) begin
        dqs_r <= 1'b0;
      end
    end
  end

  assign dq_o = dq_o_r;
  assign dq_oe = {DQ_W{rd_drive_r}};
  assign byte_data_strobe_o = {BYTES{dqs_r}};
  assign byte_data_strobe_c_o = {BYTES{~dqs_r}};
  assign byte_data_strobe_oe = {BYTES{rd_drive_r}};

  // ==========================================================
  // Bank state
  always_ff @(posedge aclk) begin
    if (!aresetn || mem_rst) begin
      open_r[0] <= '0;
      open_r[1] <= '0;
    end else begin
      for (int r = 0; r < 2; r++) begin
        if (take[r] && cmd == CMD_ACT) begin
          open_r[r][s2_r.bank] <= 1'b1;
        end else if (take[r] && cmd == CMD_PRE) begin
          if (s2_r.addr[AP_BIT]) begin
            open_r[r] <= '0;
          end else begin
            open_r[r][s2_r.bank] <= 1'b0;
          end
        end
      end
      if (wr_commit && wr_ap_r) begin
        open_r[wr_rank_r][wr_bank_r] <= 1'b0;
      end
      if (rd_launch && rd_ap_r) begin
        open_r[rd_rank_r][rd_bank_r] <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    for (int r = 0; r < 2; r++) begin
      if (take[r] && cmd == CMD_ACT) begin
        row_r[r][s2_r.bank] <= s2_r.addr;
      end
    end
  end

  // ==========================================================
  // Mode register, termination and power state
  logic [ADDR_W-1:0] mode_r;
  logic odt_en;
  logic [1:0] term_r, gate_q_r, sr_r, pd;

  assign odt_en = |(mode_r & MR_ODT_MASK);
  assign pd = ~gate_q_r & RANK_EN & ~sr_r;

  always_ff @(posedge aclk) begin
    if (!aresetn || mem_rst) begin
      mode_r <= '0;
    end else if (take[0] && cmd == CMD_MRS && s2_r.bank == MR1_BANK) begin
      mode_r <= s2_r.addr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      term_r <= '0;
    end else begin
      term_r <= s2_r.term & RANK_EN & {2{odt_en}};
    end
  end
  assign term_active = term_r;

  always_ff @(posedge aclk) begin
    if (!aresetn || mem_rst) begin
      gate_q_r <= '0;
      sr_r <= '0;
    end else if (ck_rise) begin
      gate_q_r <= s2_r.gate;
      for (int r = 0; r < 2; r++) begin
        if (s2_r.gate[r]) begin
          sr_r[r] <= 1'b0;
        end else if (gate_q_r[r] && !s2_r.sel_n[r] && cmd == CMD_REF && RANK_EN[r]) begin
          sr_r[r] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Temperature alert and presence-detect byte
  logic [7:0] temp_r, crit_r, spd_byte_r;
  logic alert_n_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alert_n_r <= 1'b1;
    end else begin
      alert_n_r <= ~(temp_r >= crit_r);
    end
  end
  assign temp_alert_n = alert_n_r;

  spd_state_t spd_st;
  logic [3:0] spd_cnt_r;
  logic [7:0] spd_sh_r;
  logic spd_rw_r, sda_oe_r, spd_start, spd_stop, scl_rise, scl_fall;

  assign spd_start = s2_r.scl && scl_prev_r && sda_prev_r && !s2_r.sda;
  assign spd_stop = s2_r.scl && scl_prev_r && !sda_prev_r && s2_r.sda;
  assign scl_rise = s2_r.scl && !scl_prev_r;
  assign scl_fall = !s2_r.scl && scl_prev_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spd_st <= SP_IDLE;
      spd_cnt_r <= '0;
      spd_sh_r <= '0;
      spd_rw_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (spd_start) begin
      spd_st <= SP_ADDR;
      spd_cnt_r <= '0;
      sda_oe_r <= 1'b0;
    end else if (spd_stop) begin
      spd_st <= SP_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      unique case (spd_st)
        SP_IDLE: begin
        end
        SP_ADDR: begin
          if (scl_rise) begin
            spd_sh_r <= {spd_sh_r[6:0], s2_r.sda};
            spd_cnt_r <= spd_cnt_r + CNT_ONE;
          end else if (scl_fall && spd_cnt_r == BIT_LAST) begin
            if (spd_sh_r[7:1] == {SPD_DEV, s2_r.strap}) begin
              spd_st <= SP_AACK;
              sda_oe_r <= 1'b1;
              spd_rw_r <= spd_sh_r[0];
            end else begin
              spd_st <= SP_IDLE;
            end
          end
        end
        SP_AACK, SP_RACK: begin
          if (scl_rise && spd_st == SP_RACK && s2_r.sda) begin
            spd_st <= SP_IDLE;
          end else if (scl_fall) begin
            if (spd_rw_r) begin
              spd_st <= SP_TX;
              spd_sh_r <= spd_byte_r;
              sda_oe_r <= ~spd_byte_r[7];
              spd_cnt_r <= '0;
            end else begin
              spd_st <= SP_IDLE;
              sda_oe_r <= 1'b0;
            end
          end
        end
        SP_TX: begin
          if (scl_rise) begin
            spd_cnt_r <= spd_cnt_r + CNT_ONE;
          end else if (scl_fall) begin
            if (spd_cnt_r == BIT_LAST) begin
              spd_st <= SP_RACK;
              sda_oe_r <= 1'b0;
            end else begin
              spd_sh_r <= {spd_sh_r[6:0], 1'b0};
              sda_oe_r <= ~spd_sh_r[6];
            end
          end
        end
        default: spd_st <= SP_IDLE;
      endcase
    end
  end
  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_r;

  // ==========================================================
  // AXI4-Lite slave
  logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r, wr_en, rmux_err;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r, rmux_data;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;

  assign awready = ~aw_hold_r & ~bvalid_r;
  assign wready = ~w_hold_r & ~bvalid_r;
  assign wr_en = aw_hold_r & w_hold_r & ~bvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = ~rvalid_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      temp_r <= '0;
      crit_r <= CRIT_DEF;
      spd_byte_r <= SPD_DEF;
    end else begin
      if (awvalid && awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_en) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= RESP_OKAY;
        case (awaddr_r)
          REG_TEMP: if (wstrb_r[0]) temp_r <= wdata_r[7:0];
          REG_CRIT: if (wstrb_r[0]) crit_r <= wdata_r[7:0];
          REG_SPD: if (wstrb_r[0]) spd_byte_r <= wdata_r[7:0];
          REG_STATUS, REG_MODE, REG_ID: begin
          end
          default: bresp_r <= RESP_SLVERR;
        endcase
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_comb begin
    rmux_data = '0;
    rmux_err = 1'b0;
    case (araddr)
      REG_STATUS: rmux_data = {12'h000, sr_r, pd, open_r[1], open_r[0]};
      REG_MODE: rmux_data = {16'h0000, mode_r};
      REG_TEMP: rmux_data = {24'h000000, temp_r};
      REG_CRIT: rmux_data = {24'h000000, crit_r};
      REG_SPD: rmux_data = {24'h000000, spd_byte_r};
      REG_ID: rmux_data = ID_VALUE;
      default: rmux_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rmux_data;
      rresp_r <= rmux_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [7:0] lane0;
  assign lane0 = mem_r[wr_idx_r][7:0];
  sequence s_quiet;
    s2_r.reset_n && !wr_commit && !rd_launch;
  endsequence
  sequence s_rd0;
    take[0] && cmd == CMD_RD && s2_r.reset_n;
  endsequence

  a_act_opens_row: assert property (take[0] && cmd == CMD_ACT ##0 s_quiet |=>
    open_r[0][$past(s2_r.bank)] && row_r[0][$past(s2_r.bank)] == $past(s2_r.addr)) else $error("row not opened");
  a_pre_all: assert property (take[0] && cmd == CMD_PRE && s2_r.addr[AP_BIT] && s2_r.reset_n |=>
    open_r[0] == '0) else $error("precharge all left a bank open");
  a_pre_one: assert property (take[0] && cmd == CMD_PRE && !s2_r.addr[AP_BIT] && s2_r.reset_n |=>
    !open_r[0][$past(s2_r.bank)]) else $error("bank not precharged");
  a_sel_ignores: assert property (ck_rise && s2_r.sel_n[0] ##0 s_quiet |=> $stable(open_r[0]))
    else $error("deselected rank changed state");
  a_gate_ignores: assert property (ck_rise && !s2_r.gate[0] ##0 s_quiet |=> $stable(open_r[0]) && $stable(mode_r))
    else $error("gated rank took a command");
  a_term_follows: assert property (1'b1 |=> term_active[0] == ($past(s2_r.term[0]) && $past(odt_en)))
    else $error("termination does not follow control and mode");
  a_read_arrives: assert property (s_rd0 ##1 (!(|take && cmd == CMD_RD) && s2_r.reset_n)[*3] |->
    ##[1:200] rd_launch) else $error("read data never launched");
  a_strobe_leads: assert property (rd_launch && s2_r.reset_n |=>
    rd_drive_r && dqs_r && dq_o == $past(rd_word) && byte_data_strobe_oe == {BYTES{1'b1}})
    else $error("read strobe not at data start");
  a_mask_blocks: assert property (wr_commit && wr_mask_r[0] && s2_r.reset_n |=> $stable(lane0))
    else $error("masked byte written");
  a_mask_stores: assert property (wr_commit && !wr_mask_r[0] && s2_r.reset_n |=> lane0 == $past(wr_data_r[7:0]))
    else $error("unmasked byte not stored");
  a_auto_pre: assert property (wr_commit && wr_ap_r && !wr_rank_r && s2_r.reset_n && !take[0] |=>
    !open_r[0][$past(wr_bank_r)]) else $error("auto-precharge missed");
  a_alert_flag: assert property (1'b1 |=> temp_alert_n == !($past(temp_r) >= $past(crit_r)))
    else $error("alert does not match temperature");
  a_reset_clears: assert property (mem_rst |=> open_r[0] == '0 && !rd_drive_r && wr_cnt_r == '0 && mode_r == '0)
    else $error("memory reset did not clear");
  a_one_rank: assert property ((RANKS < 2) |-> open_r[1] == '0 && !term_active[1])
    else $error("second rank active on single-rank build");
  a_spd_ack: assert property (spd_st == SP_AACK |-> sda_oe)
    else $error("address not acknowledged");
  a_mrs_loads: assert property (take[0] && cmd == CMD_MRS && s2_r.bank == MR1_BANK && s2_r.reset_n |=>
    mode_r == $past(s2_r.addr)) else $error("mode register not loaded");

endmodule

// ===== hdl/dimm_pkg.sv
package dimm_pkg;

  // ==========================================================
  // Geometry
  localparam int DQ_W = 64;
  localparam int BYTES = 8;
  localparam int ADDR_W = 16;
  localparam int BANK_W = 3;
  localparam int NBANK = 8;
  localparam int AP_BIT = 10;
  localparam int MEM_AW = 5;
  localparam int CL_DEF = 5;
  localparam int WL_DEF = 5;

  // ==========================================================
  // Command codes {row strobe, column strobe, write enable}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] MR1_BANK = 3'h1;
  localparam logic [15:0] MR_ODT_MASK = 16'h0244;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] BIT_LAST = 4'h8;

  // ==========================================================
  // Register map
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h04;
  localparam logic [7:0] REG_TEMP = 8'h08;
  localparam logic [7:0] REG_CRIT = 8'h0c;
  localparam logic [7:0] REG_SPD = 8'h10;
  localparam logic [7:0] REG_ID = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Arbitrary identification value
  localparam logic [31:0] ID_DEF = 32'h0000_5a01;
  localparam logic [7:0] CRIT_DEF = 8'h50;
  localparam logic [7:0] SPD_DEF = 8'h00;
  localparam logic [3:0] SPD_DEV = 4'ha;

  // ==========================================================
  // Types
  typedef struct packed {
    logic ck_t;
    logic ck_c;
    logic [1:0] gate;
    logic [1:0] sel_n;
    logic [1:0] term;
    logic [2:0] cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [BYTES-1:0] mask;
    logic [DQ_W-1:0] dq;
    logic [BYTES-1:0] strobe;
    logic reset_n;
    logic scl;
    logic sda;
    logic [2:0] strap;
  } pin_in_t;

  typedef enum {SP_IDLE, SP_ADDR, SP_AACK, SP_TX, SP_RACK} spd_state_t;

endpackage
